// ==== logic/opr_remap.sv ====
// output pin remap slice for pins 20 to 27, with avalon-mm registers
// Contract
// - register 10 bits 13..8 choose the output driven on pin 21.
// - register 10 bits 5..0 choose the output driven on pin 20.
// - register 11 bits 13..8 choose the output driven on pin 23.
// - register 11 bits 5..0 choose the output driven on pin 22.
// - register 12 bits 13..8 choose the output driven on pin 25.
// - register 12 bits 5..0 choose the output driven on pin 24.
// - register 13 bits 13..8 choose the output driven on pin 27.
// - register 13 bits 5..0 choose the output driven on pin 26.
// - bits 15 and 14 ignore writes and read zero.
// - bits 7 and 6 ignore writes and read zero.
// - selector bits are read/write and clear to zero at reset.
`timescale 1ns/1ns
`include "opr_consts.svh"
module opr_remap #(
	parameter int NUM_FUNCS = 64,
	parameter int NUM_PINS = 8
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// peripheral outputs, indexed by function number
	input wire logic [NUM_FUNCS-1:0] periph_out_i,
	input wire logic [NUM_FUNCS-1:0] periph_oe_i,
	// ordinary port logic for the pins
	input wire logic [NUM_PINS-1:0] port_out_i,
	input wire logic [NUM_PINS-1:0] port_oe_i,
	// pin drive, bit 0 is remappable_pin_20
	output logic [NUM_PINS-1:0] remappable_pin_out_o,
	output logic [NUM_PINS-1:0] remappable_pin_oe_o,
	output logic [NUM_PINS-1:0] remapped_o
);
	opr_pkg::opr_bus_req_t req;
	logic accept;
	logic [15:0] map_reg [0:3];
	logic [15:0] next_map_reg [0:3];
	logic [31:0] next_readdata;
	opr_pkg::opr_sel_t pin_sel [0:NUM_PINS-1];

	// decode an offset into a register index, invalid when unmapped
	function automatic logic [2:0] opr_decode(input logic [3:0] addr);
		unique case (addr)
			`OPR_OFS_PINS_20_21: opr_decode = 3'h0;
			`OPR_OFS_PINS_22_23: opr_decode = 3'h1;
			`OPR_OFS_PINS_24_25: opr_decode = 3'h2;
			`OPR_OFS_PINS_26_27: opr_decode = 3'h3;
			default: opr_decode = 3'h4;
		endcase
	endfunction

	// bundle the request
	assign req = '{read: avs_read, write: avs_write, address: avs_address,
		writedata: avs_writedata};

	opr_reg_slave u_slave (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.req_i(req.read || req.write),
		.waitrequest_o(avs_waitrequest),
		.accept_o(accept)
	);

	// register write: only selector bits are stored, lanes honoured
	always_comb begin
		logic [2:0] idx;
		logic [15:0] mask;
		idx = opr_decode(req.address);
		mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & `OPR_FIELD_MASK;
		for (int i = 0; i < 4; i++) begin
			next_map_reg[i] = map_reg[i];
		end
		if (accept && req.write && !idx[2]) begin
			next_map_reg[idx[1:0]] = (map_reg[idx[1:0]] & ~mask) |
				(req.writedata[15:0] & mask);
		end
	end

	// read data: loaded in the wait cycle so they stand while waitrequest is low
	always_comb begin
		logic [2:0] ridx;
		ridx = opr_decode(req.address);
		next_readdata = avs_readdata;
		if (req.read && avs_waitrequest) begin
			next_readdata = ridx[2] ? 32'h0000_0000 :
				{16'h0000, map_reg[ridx[1:0]] & `OPR_FIELD_MASK};
		end
	end

	// register state, cleared at reset
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 4; i++) begin
				map_reg[i] <= `OPR_REG_RESET;
			end
			avs_readdata <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				map_reg[i] <= next_map_reg[i];
			end
			avs_readdata <= next_readdata;
		end
	end

	// per-pin selector fields: even pin low field, odd pin high field
	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_pin
			if (p % 2 == 0) begin : g_lo
				assign pin_sel[p] = map_reg[p/2][`OPR_LO_LSB +: `OPR_SEL_W];
			end else begin : g_hi
				assign pin_sel[p] = map_reg[p/2][`OPR_HI_LSB +: `OPR_SEL_W];
			end
			opr_pin_mux #(
				.NUM_FUNCS(NUM_FUNCS)
			) u_mux (
				.sel_i(pin_sel[p]),
				.periph_out_i(periph_out_i),
				.periph_oe_i(periph_oe_i),
				.port_out_i(port_out_i[p]),
				.port_oe_i(port_oe_i[p]),
				.pin_out_o(remappable_pin_out_o[p]),
				.pin_oe_o(remappable_pin_oe_o[p]),
				.remapped_o(remapped_o[p])
			);
		end
	endgenerate

	// pick one selector field out of a mapping word; odd pins use the high field
	function automatic opr_pkg::opr_sel_t opr_field(input logic [15:0] word, input logic hi);
		opr_field = hi ? word[`OPR_HI_LSB +: `OPR_SEL_W] : word[`OPR_LO_LSB +: `OPR_SEL_W];
	endfunction

	// a selector names a real peripheral output only when nonzero and in range
	function automatic logic opr_mapped(input opr_pkg::opr_sel_t sel);
		opr_mapped = (sel != `OPR_FUNC_NONE) && (int'(sel) < NUM_FUNCS);
	endfunction

	// pin 20 takes the peripheral named by the low field of the first word
	a_pin20_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[0], 1'b0)) |-> (remapped_o[0] &&
			remappable_pin_out_o[0] == periph_out_i[opr_field(map_reg[0], 1'b0)] &&
			remappable_pin_oe_o[0] == periph_oe_i[opr_field(map_reg[0], 1'b0)]))
		else $error("pin 20 not routed from its selector");
	// pin 21 takes the peripheral named by the high field of the first word
	a_pin21_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[0], 1'b1)) |-> (remapped_o[1] &&
			remappable_pin_out_o[1] == periph_out_i[opr_field(map_reg[0], 1'b1)] &&
			remappable_pin_oe_o[1] == periph_oe_i[opr_field(map_reg[0], 1'b1)]))
		else $error("pin 21 not routed from its selector");
	// pin 22 takes the peripheral named by the low field of the second word
	a_pin22_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[1], 1'b0)) |-> (remapped_o[2] &&
			remappable_pin_out_o[2] == periph_out_i[opr_field(map_reg[1], 1'b0)] &&
			remappable_pin_oe_o[2] == periph_oe_i[opr_field(map_reg[1], 1'b0)]))
		else $error("pin 22 not routed from its selector");
	// pin 23 takes the peripheral named by the high field of the second word
	a_pin23_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[1], 1'b1)) |-> (remapped_o[3] &&
			remappable_pin_out_o[3] == periph_out_i[opr_field(map_reg[1], 1'b1)] &&
			remappable_pin_oe_o[3] == periph_oe_i[opr_field(map_reg[1], 1'b1)]))
		else $error("pin 23 not routed from its selector");
	// pin 24 takes the peripheral named by the low field of the third word
	a_pin24_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[2], 1'b0)) |-> (remapped_o[4] &&
			remappable_pin_out_o[4] == periph_out_i[opr_field(map_reg[2], 1'b0)] &&
			remappable_pin_oe_o[4] == periph_oe_i[opr_field(map_reg[2], 1'b0)]))
		else $error("pin 24 not routed from its selector");
	// pin 25 takes the peripheral named by the high field of the third word
	a_pin25_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[2], 1'b1)) |-> (remapped_o[5] &&
			remappable_pin_out_o[5] == periph_out_i[opr_field(map_reg[2], 1'b1)] &&
			remappable_pin_oe_o[5] == periph_oe_i[opr_field(map_reg[2], 1'b1)]))
		else $error("pin 25 not routed from its selector");
	// pin 26 takes the peripheral named by the low field of the fourth word
	a_pin26_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[3], 1'b0)) |-> (remapped_o[6] &&
			remappable_pin_out_o[6] == periph_out_i[opr_field(map_reg[3], 1'b0)] &&
			remappable_pin_oe_o[6] == periph_oe_i[opr_field(map_reg[3], 1'b0)]))
		else $error("pin 26 not routed from its selector");
	// pin 27 takes the peripheral named by the high field of the fourth word
	a_pin27_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		opr_mapped(opr_field(map_reg[3], 1'b1)) |-> (remapped_o[7] &&
			remappable_pin_out_o[7] == periph_out_i[opr_field(map_reg[3], 1'b1)] &&
			remappable_pin_oe_o[7] == periph_oe_i[opr_field(map_reg[3], 1'b1)]))
		else $error("pin 27 not routed from its selector");

	// a zero or out-of-range selector hands the pin back to its port logic
	a_port_fallback: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[0], 1'b0)) |-> (!remapped_o[0] &&
			remappable_pin_out_o[0] == port_out_i[0] &&
			remappable_pin_oe_o[0] == port_oe_i[0]))
		else $error("pin 20 not left to port logic");
	a_pin21_port: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[0], 1'b1)) |-> (!remapped_o[1] &&
			remappable_pin_out_o[1] == port_out_i[1] &&
			remappable_pin_oe_o[1] == port_oe_i[1]))
		else $error("pin 21 not left to port logic");
	a_pin22_port: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[1], 1'b0)) |-> (!remapped_o[2] &&
			remappable_pin_out_o[2] == port_out_i[2] &&
			remappable_pin_oe_o[2] == port_oe_i[2]))
		else $error("pin 22 not left to port logic");
	a_pin23_port: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[1], 1'b1)) |-> (!remapped_o[3] &&
			remappable_pin_out_o[3] == port_out_i[3] &&
			remappable_pin_oe_o[3] == port_oe_i[3]))
		else $error("pin 23 not left to port logic");
	a_pin24_port: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[2], 1'b0)) |-> (!remapped_o[4] &&
			remappable_pin_out_o[4] == port_out_i[4] &&
			remappable_pin_oe_o[4] == port_oe_i[4]))
		else $error("pin 24 not left to port logic");
	a_pin25_port: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[2], 1'b1)) |-> (!remapped_o[5] &&
			remappable_pin_out_o[5] == port_out_i[5] &&
			remappable_pin_oe_o[5] == port_oe_i[5]))
		else $error("pin 25 not left to port logic");
	a_pin26_port: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[3], 1'b0)) |-> (!remapped_o[6] &&
			remappable_pin_out_o[6] == port_out_i[6] &&
			remappable_pin_oe_o[6] == port_oe_i[6]))
		else $error("pin 26 not left to port logic");
	a_pin27_port: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!opr_mapped(opr_field(map_reg[3], 1'b1)) |-> (!remapped_o[7] &&
			remappable_pin_out_o[7] == port_out_i[7] &&
			remappable_pin_oe_o[7] == port_oe_i[7]))
		else $error("pin 27 not left to port logic");

	// reserved bits never hold a one
	a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		((map_reg[0] | map_reg[1] | map_reg[2] | map_reg[3]) & ~`OPR_FIELD_MASK) == 16'h0000)
		else $error("reserved bit stored");

	// a full-word write lands in its own word, reserved bits dropped
	sequence s_write_done;
		accept && req.write && avs_byteenable[1:0] == 2'b11 &&
			req.address == `OPR_OFS_PINS_20_21;
	endsequence
	a_write_stored: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_write_done |=> map_reg[0] == ($past(req.writedata[15:0]) & `OPR_FIELD_MASK))
		else $error("selector write lost");
	sequence s_write_w1;
		accept && req.write && avs_byteenable[1:0] == 2'b11 &&
			req.address == `OPR_OFS_PINS_22_23;
	endsequence
	a_write_w1: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_write_w1 |=> map_reg[1] == ($past(req.writedata[15:0]) & `OPR_FIELD_MASK))
		else $error("selector write lost in second word");
	sequence s_write_w2;
		accept && req.write && avs_byteenable[1:0] == 2'b11 &&
			req.address == `OPR_OFS_PINS_24_25;
	endsequence
	a_write_w2: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_write_w2 |=> map_reg[2] == ($past(req.writedata[15:0]) & `OPR_FIELD_MASK))
		else $error("selector write lost in third word");
	sequence s_write_w3;
		accept && req.write && avs_byteenable[1:0] == 2'b11 &&
			req.address == `OPR_OFS_PINS_26_27;
	endsequence
	a_write_w3: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_write_w3 |=> map_reg[3] == ($past(req.writedata[15:0]) & `OPR_FIELD_MASK))
		else $error("selector write lost in fourth word");

	// reset clears all selectors and the read data one edge later
	a_reset_clear: assert property (@(posedge ref_clk_i)
		sys_rst_i |=> (map_reg[0] == `OPR_REG_RESET && map_reg[1] == `OPR_REG_RESET &&
			map_reg[2] == `OPR_REG_RESET && map_reg[3] == `OPR_REG_RESET &&
			avs_readdata == 32'h0000_0000))
		else $error("reset left a selector set");

	// a request gets its answer within two cycles
	a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
		else $error("bus answer late");

	// an idle bus never shows a wait
	a_wait_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest raised without a request");

	// read data stand in the cycle where waitrequest drops
	sequence s_read_first;
		avs_read && avs_waitrequest && req.address == `OPR_OFS_PINS_20_21;
	endsequence
	sequence s_read_answer;
		!avs_waitrequest && avs_readdata == {16'h0000, map_reg[0] & `OPR_FIELD_MASK};
	endsequence
	a_read_value: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_read_first |=> s_read_answer)
		else $error("read data not standing with the answer");

	// an unmapped offset reads as zero
	a_read_unmapped: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(avs_read && avs_waitrequest && opr_decode(req.address) == 3'h4) |=>
			avs_readdata == 32'h0000_0000)
		else $error("unmapped offset read nonzero");

	// read data hold between reads
	a_read_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved without a read");

	// a write to an unmapped offset changes no selector
	a_unmapped_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(accept && req.write && opr_decode(req.address) == 3'h4) |=>
			(map_reg[0] == $past(map_reg[0]) && map_reg[1] == $past(map_reg[1]) &&
			map_reg[2] == $past(map_reg[2]) && map_reg[3] == $past(map_reg[3])))
		else $error("unmapped write stored");
endmodule

// ==== logic/opr_consts.svh ====
// constants for the output pin remap slice, pins 20 to 27
`ifndef OPR_CONSTS_SVH
`define OPR_CONSTS_SVH
`define OPR_OFS_PINS_20_21 4'h0
`define OPR_OFS_PINS_22_23 4'h4
`define OPR_OFS_PINS_24_25 4'h8
`define OPR_OFS_PINS_26_27 4'hC
`define OPR_SEL_W 6
`define OPR_LO_LSB 0
`define OPR_HI_LSB 8
`define OPR_REG_RESET 16'h0000
`define OPR_SEL_RESET 6'h00
`define OPR_FIELD_MASK 16'h3F3F
`define OPR_FUNC_NONE 6'h00
`define OPR_FIRST_PIN 20
`endif

// ==== logic/opr_pkg.sv ====
// types for the output pin remap slice
package opr_pkg;
	typedef logic [5:0] opr_sel_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} opr_bus_req_t;
	typedef enum logic [0:0] {
		OPR_IDLE,
		OPR_DONE
	} opr_bus_state_t;
endpackage

// ==== logic/opr_pin_mux.sv ====
// one remappable pin: picks a peripheral output or falls back to the port
`timescale 1ns/1ns
`include "opr_consts.svh"
module opr_pin_mux #(
	parameter int NUM_FUNCS = 64
) (
	// selector
	input wire opr_pkg::opr_sel_t sel_i,
	// sources
	input wire logic [NUM_FUNCS-1:0] periph_out_i,
	input wire logic [NUM_FUNCS-1:0] periph_oe_i,
	input wire logic port_out_i,
	input wire logic port_oe_i,
	// pin drive
	output logic pin_out_o,
	output logic pin_oe_o,
	output logic remapped_o
);
	// valid when the number names an existing function other than none
	always_comb begin
		remapped_o = (sel_i != `OPR_FUNC_NONE) && (int'(sel_i) < NUM_FUNCS);
		if (remapped_o) begin
			pin_out_o = periph_out_i[sel_i];
			pin_oe_o = periph_oe_i[sel_i];
		end else begin
			pin_out_o = port_out_i; // port logic keeps the pin
			pin_oe_o = port_oe_i;
		end
	end
endmodule

// ==== logic/opr_reg_slave.sv ====
// avalon-mm handshake: one wait cycle, then acknowledge
`timescale 1ns/1ns
module opr_reg_slave (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// request
	input wire logic req_i,
	// answer
	output logic waitrequest_o,
	output logic accept_o
);
	opr_pkg::opr_bus_state_t state;
	opr_pkg::opr_bus_state_t next_state;
	// next state: take on the second cycle of a request
	always_comb begin
		next_state = state;
		unique case (state)
			opr_pkg::OPR_IDLE: begin
				if (req_i) begin
					next_state = opr_pkg::OPR_DONE;
				end
			end
			opr_pkg::OPR_DONE: begin
				next_state = opr_pkg::OPR_IDLE;
			end
		endcase
	end
	// state register
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state <= opr_pkg::OPR_IDLE;
		end else begin
			state <= next_state;
		end
	end
	// handshake outputs
	assign accept_o = req_i && (state == opr_pkg::OPR_DONE);
	assign waitrequest_o = req_i && (state != opr_pkg::OPR_DONE);
endmodule

// ==== verification/opr_periph_model.sv ====
// peripheral outputs and port drive that face the remap slice
`timescale 1ns/1ns
module opr_periph_model #(
	parameter int NUM_FUNCS = 40
) (
	// clock
	input wire logic ref_clk_i,
	// drive toward the slice
	output logic [NUM_FUNCS-1:0] periph_out_o,
	output logic [NUM_FUNCS-1:0] periph_oe_o,
	output logic [7:0] port_out_o,
	output logic [7:0] port_oe_o
);
	// distinct start patterns so a wrong select shows, then the outputs invert and the enables rotate each cycle
	initial begin
		periph_out_o = NUM_FUNCS'(64'hA5C3_0F96_3C5A_F0E1);
		periph_oe_o = NUM_FUNCS'(64'h6D2B_91E4_7C08_B35A);
		port_out_o = 8'h96;
		port_oe_o = 8'h3C;
		forever begin
			@(posedge ref_clk_i);
			periph_out_o <= ~periph_out_o;
			periph_oe_o <= {periph_oe_o[NUM_FUNCS-2:0], periph_oe_o[NUM_FUNCS-1]};
			port_out_o <= ~port_out_o;
			port_oe_o <= {port_oe_o[6:0], port_oe_o[7]};
		end
	end
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the output pin remap slice
`timescale 1ns/1ns
module tb;
	localparam int NF = 40;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [NF-1:0] periph_out;
	logic [NF-1:0] periph_oe;
	logic [7:0] port_out, port_oe, pin_out, pin_oe, remapped;
	logic [15:0] sh [4];
	logic [31:0] q;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	// rows: address, write data, byte lanes; 63 and 40 lie past the last function
	logic [3:0] r_adr [6] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h0, 4'h4};
	logic [15:0] r_dat [6] = '{16'hE5D2, 16'h0A05, 16'h3F27, 16'h1128, 16'hC000, 16'h01FF};
	logic [1:0] r_be [6] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2};

	// clock, 4 ns period
	always #2 ref_clk_i = ~ref_clk_i;

	opr_remap #(.NUM_FUNCS(NF), .NUM_PINS(8)) u_opr_remap (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.periph_out_i(periph_out), .periph_oe_i(periph_oe),
		.port_out_i(port_out), .port_oe_i(port_oe),
		.remappable_pin_out_o(pin_out), .remappable_pin_oe_o(pin_oe),
		.remapped_o(remapped)
	);
	opr_periph_model #(.NUM_FUNCS(NF)) u_opr_periph_model (
		.ref_clk_i(ref_clk_i), .periph_out_o(periph_out), .periph_oe_o(periph_oe),
		.port_out_o(port_out), .port_oe_o(port_oe)
	);

	task automatic end_of_test();
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer; read data taken at the edge where waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
		input logic [1:0] be, output logic [31:0] rd);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= {2'b00, be};
		do begin
			@(posedge ref_clk_i);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	// expected pin drive from the shadow selectors and the far-side sources
	task automatic chk_pins();
		logic [7:0] eo, ee, er;
		logic [5:0] s;
		@(negedge ref_clk_i);
		for (int p = 0; p < 8; p++) begin
			s = p[0] ? sh[p/2][13:8] : sh[p/2][5:0];
			er[p] = (s != 6'h00) && (s < NF);
			eo[p] = er[p] ? periph_out[s] : port_out[p];
			ee[p] = er[p] ? periph_oe[s] : port_oe[p];
		end
		chk({8'h00, remapped, pin_oe, pin_out}, {8'h00, er, ee, eo});
		@(posedge ref_clk_i);
	endtask

	// hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// main sequence: table rows, then unmapped access and a second reset
	initial begin
		for (int i = 0; i < 4; i++) sh[i] = 16'h0000;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		chk_pins();
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, r_adr[i], r_dat[i], r_be[i], q);
			if (r_be[i][0]) sh[r_adr[i][3:2]][7:0] = r_dat[i][7:0] & 8'h3F;
			if (r_be[i][1]) sh[r_adr[i][3:2]][15:8] = r_dat[i][15:8] & 8'h3F;
			chk_pins();
			bus(1'b0, r_adr[i], 16'h0000, 2'h3, q);
			chk(q, {16'h0000, sh[r_adr[i][3:2]]});
		end
		// unmapped place: write must not land in any selector, read gives zero
		bus(1'b1, 4'h2, 16'hFFFF, 2'h3, q);
		chk_pins();
		bus(1'b0, 4'h2, 16'h0000, 2'h3, q);
		chk(q, 32'h0000_0000);
		// reset in mid-run clears every selector
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		for (int i = 0; i < 4; i++) sh[i] = 16'h0000;
		chk_pins();
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 4'(i * 4), 16'h0000, 2'h3, q);
			chk(q, 32'h0000_0000);
		end
		end_of_test();
	end
endmodule
